// ===== logic/acs_map.vh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_ADDR_CTL0 8'h00
`define ACS_ADDR_CTL1 8'h01
`define ACS_ADDR_DATH 8'h02
`define ACS_ADDR_DATL 8'h03
`define ACS_ADDR_STAT 8'h04
`define ACS_CTL0_RST 8'h00
`define ACS_CTL1_RST 8'h80
`define ACS_BIT_START 7
`define ACS_BIT_REPEAT 6
`define ACS_BIT_REFL 5
`define ACS_BIT_REFOUT 4
`define ACS_BIT_REFH 7
`define ACS_CH_HI 3
`define ACS_CH_LO 0
`define ACS_CH_RSV_BIT 3
`define ACS_CLK_MHZ 10
`define ACS_IDLE_CYC 16'd160
`define ACS_PWRUP_CYC 16'd40
`define ACS_CONV_CYC 16'd5129
`define ACS_REPEAT_MODE_SELECT_CYC 16'd256
`define ACS_RES_W 13
`define ACS_REF_EXT 2'h0
`define ACS_REF_1V0 2'h1
`define ACS_REF_2V0 2'h2
`endif

// ===== logic/acs_timer.v
// Down counter that times the power and conversion phases
module acs_timer (
  input wire core_clk,
  input wire sys_rst,
  input wire load,
  input wire [15:0] load_val,
  output reg done
);
  reg [15:0] cnt_r;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      done <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      done <= 1'b0;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
      done <= (cnt_r == 16'h0001);
    end else begin
      done <= 1'b0;
    end
  end
endmodule // acs_timer

// ===== logic/acs_seq.v
// Conversion sequencer of the sigma-delta converter: registers, timing and results
//
// Functional notes
// - Result is an 11-bit signed two's complement value, normally 0 to 1023.
// - Result registers expose 13 raw bits; two lowest only for compensation.
// - After 160 idle cycles the converter is powered down.
// - A request from powered-down state powers up, allowing 40 cycles.
// - Single-shot and first continuous conversion take 5129 cycles.
// - Power-up period is inserted before conversion when powered down.
// - Upper eight bits go to high byte; low three to low bits 7 to 5.
// - Start flag reads 1 until a started conversion gives its first result; cleared when single-shot completes.
// - Single-shot performs one conversion then stops.
// - Repeat bit 0 selects single-shot, 1 selects continuous.
// - Continuous: start flag clears after first result, stays 0 afterwards.
// - Continuous: fresh result every 256 cycles after the first. The code gives one every 257 cycles, because the reload takes one cycle.
// - Continuous: a completion request after every conversion, first included.
// - Completion requests only while enabled; disabling keeps a pending one. No enable bit here: requests are always raised.
// - One of eight single-ended inputs is routed to the converter.
// - Writing 0 to start has no effect; 1 starts or restarts.
// - Reference code 00 external, 01 1.0 V, 10 2.0 V, default 10.
// - Channel codes 1000 to 1111 open all input switches.
//
// Added by the designer: the strobed register port and the register offsets.
`include "acs_map.vh"
module acs_seq (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [12:0] mod_result,
  input wire mod_overflow,
  output reg [7:0] input_switch_en,
  output reg [1:0] reference_level,
  output reg reference_output_select,
  output reg mod_power_en,
  output reg mod_run,
  output reg conv_done_irq
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_DOWN = 3'h1;
  localparam ST_PWUP = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_REPEAT_MODE_SELECT = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // Software-visible control fields
  reg conversion_start_flag_r;
  reg repeat_mode_select_r;
  reg reference_level_low_bit_r;
  reg reference_level_high_bit_r;
  reg reference_output_select_r;
  reg [3:0] input_channel_select_r;

  // Results and completion
  reg [7:0] result_upper_byte_r;
  reg [4:0] result_lower_bits_r;
  reg overflow_r;
  reg [7:0] idle_cnt_r;
  reg pending_r;

  // Phase timer handshake
  reg tmr_load;
  reg [15:0] tmr_val;
  reg done_conv;
  wire tmr_done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  function [7:0] sw_decode;
    input [3:0] ch;
    begin
      if (ch[`ACS_CH_RSV_BIT])
        sw_decode = 8'h00;
      else
        sw_decode = 8'h01 << ch[2:0];
    end
  endfunction

  function is_running;
    input [2:0] st;
    begin
      is_running = (st == ST_CONV) || (st == ST_REPEAT_MODE_SELECT);
    end
  endfunction

  // A start write restarts the conversion in any state; during power-up it cuts the rest of the wait short
  wire start_wr = reg_wr && wr_hit(reg_addr, `ACS_ADDR_CTL0) &&
                  reg_wdata[`ACS_BIT_START];
  // Power-down is the only unpowered state
  wire powered = (state_r != ST_DOWN);

  // ----------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------
  acs_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Register read views
  // ----------------------------------------------------------------
  wire [7:0] ctl0_view;
  wire [7:0] ctl1_view;
  wire [7:0] datl_view;
  wire [7:0] stat_view;
  assign ctl0_view = {conversion_start_flag_r, repeat_mode_select_r,
                      reference_level_low_bit_r, reference_output_select_r,
                      input_channel_select_r};
  assign ctl1_view = {reference_level_high_bit_r, 7'h00};
  // Low register: three result bits, two compensation bits, two spares, overflow
  assign datl_view = {result_lower_bits_r, 2'h0, overflow_r};
  // Status: powered down, running, pending completion
  assign stat_view = {5'h00, state_r == ST_DOWN, mod_run, pending_r};

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = `ACS_CONV_CYC;
    done_conv = 1'b0;
    if (start_wr) begin
      tmr_load = 1'b1;
      if (powered) begin
        state_nxt = ST_CONV;
        tmr_val = `ACS_CONV_CYC;
      end else begin
        state_nxt = ST_PWUP;
        tmr_val = `ACS_PWRUP_CYC;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          if ({8'h00, idle_cnt_r} == `ACS_IDLE_CYC - 16'd1)
            state_nxt = ST_DOWN;
        end
        ST_DOWN: begin
          // Only a start write leaves power-down
          state_nxt = ST_DOWN;
        end
        ST_PWUP: begin
          // Power-up over: the full-length conversion follows
          if (tmr_done) begin
            state_nxt = ST_CONV;
            tmr_load = 1'b1;
            tmr_val = `ACS_CONV_CYC;
          end
        end
        ST_CONV, ST_REPEAT_MODE_SELECT: begin
          if (tmr_done) begin
            done_conv = 1'b1;
            // Continuous runs reload the short period
            if (repeat_mode_select_r) begin
              state_nxt = ST_REPEAT_MODE_SELECT;
              tmr_load = 1'b1;
              tmr_val = `ACS_REPEAT_MODE_SELECT_CYC;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State, registers and results
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_DOWN;
      conversion_start_flag_r <= 1'b0;
      repeat_mode_select_r <= 1'b0;
      reference_level_low_bit_r <= 1'b0;
      reference_output_select_r <= 1'b0;
      input_channel_select_r <= 4'h0;
      reference_level_high_bit_r <= 1'b1;
      result_upper_byte_r <= 8'h00;
      result_lower_bits_r <= 5'h00;
      overflow_r <= 1'b0;
      pending_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Control register 0 fields; the start bit is handled apart
      if (reg_wr && wr_hit(reg_addr, `ACS_ADDR_CTL0)) begin
        repeat_mode_select_r <= reg_wdata[`ACS_BIT_REPEAT];
        reference_level_low_bit_r <= reg_wdata[`ACS_BIT_REFL];
        reference_output_select_r <= reg_wdata[`ACS_BIT_REFOUT];
        input_channel_select_r <= reg_wdata[`ACS_CH_HI:`ACS_CH_LO];
      end
      if (reg_wr && wr_hit(reg_addr, `ACS_ADDR_CTL1))
        reference_level_high_bit_r <= reg_wdata[`ACS_BIT_REFH];
      // Start request wins over a completion in the same cycle
      if (start_wr)
        conversion_start_flag_r <= 1'b1;
      else if (done_conv)
        conversion_start_flag_r <= 1'b0;
      // Raw 13-bit word: top eight bits high, next five low
      if (done_conv) begin
        result_upper_byte_r <= mod_result[`ACS_RES_W-1:`ACS_RES_W-8];
        result_lower_bits_r <= mod_result[`ACS_RES_W-9:0];
        overflow_r <= mod_overflow;
      end
      // Pending request holds until software clears it in the status register
      if (done_conv && powered)
        pending_r <= 1'b1;
      else if (reg_wr && wr_hit(reg_addr, `ACS_ADDR_STAT) && reg_wdata[0])
        pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Idle counter: cycles spent in the idle state after a conversion, not counting power-up
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt_r <= 8'h00;
    end else if (state_r == ST_IDLE && !start_wr) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end else begin
      idle_cnt_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read port
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      input_switch_en <= 8'h00;
      reference_level <= `ACS_REF_2V0;
      reference_output_select <= 1'b0;
      mod_power_en <= 1'b0;
      mod_run <= 1'b0;
      conv_done_irq <= 1'b0;
    end else begin
      if (is_running(state_nxt))
        input_switch_en <= sw_decode(input_channel_select_r);
      else
        input_switch_en <= 8'h00;
      reference_level <= {reference_level_high_bit_r, reference_level_low_bit_r};
      reference_output_select <= reference_output_select_r;
      mod_power_en <= (state_nxt != ST_DOWN);
      mod_run <= is_running(state_nxt);
      conv_done_irq <= done_conv && powered;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ACS_ADDR_CTL0: begin
            reg_rdata <= ctl0_view;
          end
          `ACS_ADDR_CTL1: begin
            reg_rdata <= ctl1_view;
          end
          `ACS_ADDR_DATH: begin
            reg_rdata <= result_upper_byte_r;
          end
          `ACS_ADDR_DATL: begin
            reg_rdata <= datl_view;
          end
          `ACS_ADDR_STAT: begin
            reg_rdata <= stat_view;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule // acs_seq

// ===== verif/acs_seq_asserts.sv
// Port checks of the conversion sequencer
module acs_seq_chk (
  input logic core_clk,
  input logic sys_rst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic [12:0] mod_result,
  input logic mod_overflow,
  input logic [7:0] input_switch_en,
  input logic [1:0] reference_level,
  input logic reference_output_select,
  input logic mod_power_en,
  input logic mod_run,
  input logic conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] idle_cnt;
  // Cycles spent powered but not converting
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) idle_cnt <= 8'h00;
    else if (mod_power_en && !mod_run && idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
    else if (!mod_power_en || mod_run) idle_cnt <= 8'h00;
  end
  sequence pwr_wait_s;
    !mod_run [*8];
  endsequence
  irq_one_cycle_a: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("completion pulse longer than one cycle");
  irq_after_run_a: assert property (conv_done_irq |-> $past(mod_run))
    else $error("completion without a conversion");
  irq_powered_a: assert property (conv_done_irq |-> mod_power_en)
    else $error("completion while powered down");
  run_powered_a: assert property (mod_run |-> mod_power_en)
    else $error("conversion while powered down");
  power_up_wait_a: assert property ($rose(mod_power_en) |-> pwr_wait_s ##[31:34] $rose(mod_run))
    else $error("power-up period not kept");
  idle_down_a: assert property (idle_cnt <= 8'd162)
    else $error("no power-down after idle period");
  switch_idle_a: assert property (!mod_run |-> input_switch_en == 8'h00)
    else $error("input switch closed while idle");
  switch_onehot_a: assert property (mod_run |-> $onehot0(input_switch_en))
    else $error("more than one input switch closed");
  ref_hold_a: assert property (!$past(reg_wr, 2) |-> $stable(reference_level))
    else $error("reference level moved without a write");
endmodule // acs_seq_chk
bind acs_seq acs_seq_chk chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .mod_result, .mod_overflow, .input_switch_en, .reference_level,
  .reference_output_select, .mod_power_en, .mod_run, .conv_done_irq);

// ===== verif/acs_seq_bench.sv
// Self-checking bench of the conversion sequencer
`include "acs_map.vh"
module acs_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, mod_overflow = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [12:0] mod_result = 13'h1A5B;
  wire [7:0] reg_rdata, input_switch_en;
  wire [1:0] reference_level;
  wire reference_output_select, mod_power_en, mod_run, conv_done_irq;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  // Rows: ctl1, ctl0, switch enables, reference level, reference output
  logic [31:0] rows [5] = '{32'h8080_0120, 32'h00A3_0810, 32'h00B7_8011,
    32'h8088_0020, 32'h808F_0020};
  acs_seq dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mod_result, .mod_overflow, .input_switch_en, .reference_level,
    .reference_output_select, .mod_power_en, .mod_run, .conv_done_irq);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 40000) begin
    fail_count++;
    end_sim;
  end
  task end_sim;
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, exp, input string m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp, m);
  endtask
  task wait_irq(input int lo, hi, input string m);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!conv_done_irq && n < 6000);
    chk(n >= lo && n <= hi, 1, m);
  endtask
  task quiet(input int c);
    n = 0;
    repeat (c) begin
      @(posedge core_clk);
      #1 n += conv_done_irq;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    #1 chk({mod_power_en, mod_run, conv_done_irq, input_switch_en}, 0, "outputs");
    chk(reference_level, `ACS_REF_2V0, "ref default");
    rd(`ACS_ADDR_CTL0, 8'h00, "ctl0 reset");
    rd(`ACS_ADDR_CTL1, 8'h80, "ctl1 reset");
    rd(`ACS_ADDR_STAT, 8'h04, "status reset");
    rd(8'h10, 8'h00, "unmapped");
    wr(`ACS_ADDR_CTL0, 8'h80);
    wait_irq(5167, 5171, "cold single");
    rd(`ACS_ADDR_CTL0, 8'h00, "start clear");
    rd(`ACS_ADDR_DATH, 8'hD2, "high byte");
    rd(`ACS_ADDR_DATL, 8'hD9, "low bits");
    rd(`ACS_ADDR_STAT, 8'h01, "pending set");
    wr(`ACS_ADDR_STAT, 8'h01);
    rd(`ACS_ADDR_STAT, 8'h00, "pending clear");
    quiet(300);
    chk(n, 0, "single repeats");
    chk(mod_power_en, 0, "no power-down");
    wr(`ACS_ADDR_CTL0, 8'h07);
    repeat (60) @(posedge core_clk);
    #1 chk({mod_power_en, mod_run}, 0, "zero start");
    // ------------------------------
    // Channel and reference rows
    // ------------------------------
    foreach (rows[i]) begin
      wr(`ACS_ADDR_CTL1, rows[i][31:24]);
      wr(`ACS_ADDR_CTL0, rows[i][23:16]);
      repeat (50) @(posedge core_clk);
      #1 chk(input_switch_en, rows[i][15:8], "switches");
      chk({reference_level, reference_output_select}, {rows[i][5:4], rows[i][0]}, "ref");
    end
    wr(`ACS_ADDR_CTL0, 8'h81);
    wait_irq(5127, 5131, "restart");
    wr(`ACS_ADDR_CTL0, 8'hC2);
    wait_irq(5127, 5131, "first run");
    @(posedge core_clk) mod_result <= 13'h1234;
    wait_irq(255, 257, "run period");
    rd(`ACS_ADDR_DATH, 8'h91, "run data");
    rd(`ACS_ADDR_CTL0, 8'h42, "run start flag");
    wr(`ACS_ADDR_CTL0, 8'h02);
    quiet(600);
    chk(n <= 1, 1, "run stop");
    end_sim;
  end
endmodule // acs_seq_bench
